// >>> design/iofsar_pkg.sv
// Package for the digital input function select and alarm relay block
package iofsar_pkg;
    localparam int DATA_W = 32;
    localparam int VAL_W = 16;
    // Register byte offsets
    localparam logic [11:0] OFS_DIN_FUNC = 12'h000;
    localparam logic [11:0] OFS_CONFIG = 12'h004;
    localparam logic [11:0] OFS_AIN_RANGE1 = 12'h008;
    localparam logic [11:0] OFS_AIN_RANGE2 = 12'h00C;
    localparam logic [11:0] OFS_STATUS = 12'h010;
    localparam logic [11:0] OFS_SETPOINT = 12'h014;
    localparam logic [11:0] OFS_AIN2_PCT = 12'h018;
    localparam logic [11:0] OFS_RETX = 12'h01C;
    // Digital input function codes
    typedef enum logic [3:0] {
        IOFSAR_FN_NONE = 4'h0,
        IOFSAR_FN_ENABLE = 4'h1,
        IOFSAR_FN_VFB = 4'h2,
        IOFSAR_FN_LOCAL_REMOTE = 4'h3,
        IOFSAR_FN_PHASE_ANGLE = 4'h4,
        IOFSAR_FN_SP_SELECT = 4'h5,
        IOFSAR_FN_LOGGING = 4'h6,
        IOFSAR_FN_BAKEOUT = 4'h7,
        IOFSAR_FN_ALARM_RESET = 4'h8,
        IOFSAR_FN_FOLLOW = 4'h9
    } iofsar_fn_t;
    // Config field positions
    localparam int CFG_FB_LSB = 0;
    localparam int CFG_FIRE_LSB = 4;
    localparam int CFG_LOG_BIT = 8;
    localparam int CFG_BAKE_BIT = 9;
    localparam int CFG_LOCAL_BIT = 10;
    localparam int CFG_AIN2_LSB = 12;
    localparam int CFG_ALM_LSB = 16;
    localparam int CFG_RETX_LSB = 20;
    localparam int CFG_RSCALE_LSB = 24;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] DIN_FUNC_RESET = 32'h0000_0000;
    localparam logic [31:0] RANGE1_RESET = 32'hFFFF_0000;
    localparam logic [31:0] RANGE2_RESET = 32'hFFFF_0000;
    localparam logic [3:0] FB_VOLTAGE = 4'h0;
    localparam logic [3:0] FIRE_PHASE_ANGLE = 4'h0;
    // Alarm selection bits
    localparam int ALM_HB = 0;
    localparam int ALM_SC = 1;
    localparam int ALM_IL = 2;
    localparam int ALM_WE = 3;
    // Second analog input usage
    localparam logic [1:0] AIN2_ALT_SP = 2'h0;
    localparam logic [1:0] AIN2_EXT_FB = 2'h1;
    localparam logic [1:0] AIN2_CUR_LIM = 2'h2;
    // Retransmit choices
    localparam logic [1:0] RETX_SP = 2'h0;
    localparam logic [1:0] RETX_CUR = 2'h1;
    localparam logic [1:0] RETX_VOLT = 2'h2;
    localparam logic [1:0] RETX_PWR = 2'h3;
    // Debounce timing
    localparam int CLK_HZ = 25_000_000;
    localparam int DEBOUNCE_US = 10;
    localparam int DEBOUNCE_CYC = (DEBOUNCE_US * (CLK_HZ / 1_000_000));
    typedef struct packed {
        logic power_on;
        logic follow_mode;
        logic force_vfb;
        logic [3:0] feedback_type;
        logic force_phase;
        logic [3:0] firing_type;
        logic local_sp;
        logic remote_ain2;
        logic logging_on;
        logic bakeout_on;
        logic alarm_reset;
    } iofsar_ctrl_t;
    typedef struct packed {
        logic heater_break_alarm;
        logic thyristor_short_alarm;
        logic current_limit_alarm;
        logic watchdog_error;
        logic heatsink_over_temp;
    } iofsar_alarm_t;
endpackage : iofsar_pkg

// >>> design/iofsar_debounce.sv
// Two-stage synchroniser and stability debounce for one digital input
`timescale 1ns/10ps
module iofsar_debounce #(
    parameter int COUNT = iofsar_pkg::DEBOUNCE_CYC
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic din_i,
    output logic dout_o
);
    import iofsar_pkg::*;
    localparam int CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] CNT_MAX = CW'(COUNT);
    logic sync1_r;
    logic sync2_r;
    logic [CW-1:0] cnt_r;
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= din_i;
            sync2_r <= sync1_r;
        end
    end
    // Only a level stable for the full count is accepted
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            cnt_r <= '0;
            dout_o <= 1'b0;
        end else if (sync2_r == dout_o) begin
            cnt_r <= '0;
        end else if (cnt_r == CNT_MAX) begin
            cnt_r <= '0;
            dout_o <= sync2_r;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule : iofsar_debounce

// >>> design/iofsar_top.sv
// Digital input function select, analog scaling, alarm relay and retransmit
// Contract
// - Enable function: power output off while that input is inactive.
// - Both inputs on enable: second input decides, first ignored.
// - Feedback override active forces voltage feedback, else configured type.
// - Local/remote active: keypad or comms set point; inactive: analog input.
// - Input holding local/remote makes the front-panel button ineffective.
// - Firing override active forces phase angle, else configured firing.
// - Set point select: inactive picks analog input 1, active input 2.
// - Analog set point select matters only while remote set point used.
// - Logging input active records data, overriding logging setting.
// - Bakeout input active enables bakeout, overriding bakeout setting.
// - Alarm reset active clears heater break and holds relay normal, except on heat-sink over-temperature.
// - Follow input switches power with the input; time-proportioned use only (here follow acts under any firing type, phase angle included).
// - Analog input 1 percentage is measured value scaled against its configured range.
// - Analog input 2 scaled against its configured range.
// - Analog input 2 is alternate set point, external feedback or current limit.
// - Relay de-energised on any selected alarm; energised with aux power, no alarm.
// - Alarm selection picks heater break, short, current limit, watchdog.
// - Heat-sink over-temperature always drops the relay.
// - Heater break and short monitored only when selected.
// - Retransmit carries set point, current, voltage or power, scaled.
// - Current limit alarm active while limit loop overrides demand loop.
`timescale 1ns/10ps
module iofsar_top #(
    parameter int DEBOUNCE_COUNT = iofsar_pkg::DEBOUNCE_CYC
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [iofsar_pkg::DATA_W-1:0] pwdata_i,
    output logic [iofsar_pkg::DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [1:0] din_i,
    input wire logic lr_button_i,
    input wire logic aux_power_i,
    input wire logic [iofsar_pkg::VAL_W-1:0] ain1_i,
    input wire logic [iofsar_pkg::VAL_W-1:0] ain2_i,
    input wire logic [iofsar_pkg::VAL_W-1:0] local_sp_i,
    input wire logic [iofsar_pkg::VAL_W-1:0] meas_current_i,
    input wire logic [iofsar_pkg::VAL_W-1:0] meas_voltage_i,
    input wire logic [iofsar_pkg::VAL_W-1:0] meas_power_i,
    input wire logic demand_on_i,
    input wire logic heater_break_i,
    input wire logic thyristor_short_i,
    input wire logic limit_override_i,
    input wire logic watchdog_error_i,
    input wire logic heatsink_hot_i,
    output iofsar_pkg::iofsar_ctrl_t ctrl_o,
    output iofsar_pkg::iofsar_alarm_t alarm_o,
    output logic alarm_relay_o,
    output logic [iofsar_pkg::VAL_W-1:0] setpoint_o,
    output logic [iofsar_pkg::VAL_W-1:0] ext_feedback_o,
    output logic [iofsar_pkg::VAL_W-1:0] current_limit_sp_o,
    output logic current_limit_sp_valid_o,
    output logic [iofsar_pkg::VAL_W-1:0] retransmit_o
);
    import iofsar_pkg::*;
    localparam int VW = VAL_W;
    localparam logic [VW-1:0] FULL = {VW{1'b1}};

    logic [31:0] din_func_r;
    logic [31:0] config_r;
    logic [31:0] range1_r;
    logic [31:0] range2_r;

    logic [1:0] din_clean;
    logic [1:0] lr_btn_d_r;
    logic local_toggle_r;

    iofsar_fn_t fn [2];
    logic [1:0] act [10];

    logic [VW-1:0] ain1_pct;
    logic [VW-1:0] ain2_pct;

    logic [VW-1:0] sp_nxt;
    logic [VW-1:0] rt_nxt;
    logic relay_nxt;
    iofsar_ctrl_t ctrl_nxt;
    iofsar_alarm_t alarm_nxt;

    // Synchronised and debounced digital inputs
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_din
            iofsar_debounce #(
                .COUNT(DEBOUNCE_COUNT)
            ) u_deb (
                .clk_sys_i(clk_sys_i),
                .reset_i(reset_i),
                .din_i(din_i[gi]),
                .dout_o(din_clean[gi])
            );
            assign fn[gi] = iofsar_fn_t'(din_func_r[gi*4 +: 4]);
        end
    endgenerate

    // Per function: which inputs hold it, act[f][i]
    always_comb begin
        for (int f = 0; f < 10; f++) begin
            for (int i = 0; i < 2; i++) begin
                act[f][i] = (fn[i] == iofsar_fn_t'(f));
            end
        end
    end

    // State of the function's input; input 2 wins when both hold it
    function automatic logic fn_level(input logic [1:0] held, input logic [1:0] lvl);
        fn_level = held[1] ? lvl[1] : lvl[0];
    endfunction : fn_level

    // Scale a reading between the range low and high ends to a 16-bit fraction
    function automatic logic [VW-1:0] scale(input logic [VW-1:0] v, input logic [31:0] rng);
        logic [VW-1:0] lo;
        logic [VW-1:0] hi;
        logic [2*VW-1:0] num;
        logic [VW-1:0] span;

        lo = rng[VW-1:0];
        hi = rng[31:VW];
        span = hi - lo;

        if (v <= lo || span == '0) begin
            scale = '0;
        end else if (v >= hi) begin
            scale = FULL;
        end else begin
            num = {(v - lo), {VW{1'b0}}} / {{VW{1'b0}}, span};
            scale = num[VW-1:0];
        end
    endfunction : scale

    assign ain1_pct = scale(ain1_i, range1_r);
    assign ain2_pct = scale(ain2_i, range2_r);

    // Front-panel button toggles source only when no input owns it
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            lr_btn_d_r <= 2'b00;
            local_toggle_r <= 1'b0;
        end else begin
            lr_btn_d_r <= {lr_btn_d_r[0], lr_button_i};
            if (lr_btn_d_r == 2'b01 && act[IOFSAR_FN_LOCAL_REMOTE] == 2'b00) begin
                local_toggle_r <= ~local_toggle_r;
            end
        end
    end

    always_comb begin
        logic en_held;
        logic lr_held;
        logic remote_sp;
        remote_sp = 1'b0;

        en_held = |act[IOFSAR_FN_ENABLE];
        lr_held = |act[IOFSAR_FN_LOCAL_REMOTE];
        ctrl_nxt = '0;

        // Follow mode gates power directly; no internal time proportioning
        ctrl_nxt.follow_mode = |act[IOFSAR_FN_FOLLOW];
        ctrl_nxt.power_on = demand_on_i;
        if (ctrl_nxt.follow_mode) begin
            ctrl_nxt.power_on = fn_level(act[IOFSAR_FN_FOLLOW], din_clean);
        end

        if (en_held && !fn_level(act[IOFSAR_FN_ENABLE], din_clean)) begin
            ctrl_nxt.power_on = 1'b0;
        end

        ctrl_nxt.force_vfb = (|act[IOFSAR_FN_VFB]) && fn_level(act[IOFSAR_FN_VFB], din_clean);
        ctrl_nxt.feedback_type = ctrl_nxt.force_vfb ? FB_VOLTAGE
                                                    : config_r[CFG_FB_LSB +: 4];
        ctrl_nxt.force_phase = (|act[IOFSAR_FN_PHASE_ANGLE])
                               && fn_level(act[IOFSAR_FN_PHASE_ANGLE], din_clean);
        ctrl_nxt.firing_type = ctrl_nxt.force_phase ? FIRE_PHASE_ANGLE
                                                    : config_r[CFG_FIRE_LSB +: 4];

        if (lr_held) begin
            ctrl_nxt.local_sp = fn_level(act[IOFSAR_FN_LOCAL_REMOTE], din_clean);
        end else begin
            ctrl_nxt.local_sp = config_r[CFG_LOCAL_BIT] ^ local_toggle_r;
        end

        remote_sp = !ctrl_nxt.local_sp;
        ctrl_nxt.remote_ain2 = remote_sp && (|act[IOFSAR_FN_SP_SELECT])
                               && fn_level(act[IOFSAR_FN_SP_SELECT], din_clean);

        ctrl_nxt.logging_on = ((|act[IOFSAR_FN_LOGGING]) ?
                               fn_level(act[IOFSAR_FN_LOGGING], din_clean)
                               : config_r[CFG_LOG_BIT]);

        ctrl_nxt.bakeout_on = ((|act[IOFSAR_FN_BAKEOUT]) ?
                               fn_level(act[IOFSAR_FN_BAKEOUT], din_clean)
                               : config_r[CFG_BAKE_BIT]);

        ctrl_nxt.alarm_reset = (|act[IOFSAR_FN_ALARM_RESET])
                               && fn_level(act[IOFSAR_FN_ALARM_RESET], din_clean);

        if (ctrl_nxt.local_sp) begin
            sp_nxt = local_sp_i;
        end else if (ctrl_nxt.remote_ain2) begin
            sp_nxt = ain2_pct;
        end else begin
            sp_nxt = ain1_pct;
        end
    end

    // Alarm qualification and relay drive
    always_comb begin
        logic [3:0] sel;
        logic any;
        any = 1'b0;
        sel = config_r[CFG_ALM_LSB +: 4];

        alarm_nxt.heater_break_alarm = sel[ALM_HB] && heater_break_i
                                       && !ctrl_nxt.alarm_reset;
        alarm_nxt.thyristor_short_alarm = sel[ALM_SC] && thyristor_short_i;
        alarm_nxt.current_limit_alarm = limit_override_i;
        alarm_nxt.watchdog_error = watchdog_error_i;
        alarm_nxt.heatsink_over_temp = heatsink_hot_i;

        any = alarm_nxt.heater_break_alarm || alarm_nxt.thyristor_short_alarm
              || (sel[ALM_IL] && alarm_nxt.current_limit_alarm)
              || (sel[ALM_WE] && alarm_nxt.watchdog_error);

        // Alarm reset masks selected conditions, never over-temperature
        relay_nxt = aux_power_i && (ctrl_nxt.alarm_reset || !any);
        if (heatsink_hot_i) begin
            relay_nxt = 1'b0;
        end
    end

    // Retransmit selection, then scale as a fraction of full span
    always_comb begin
        logic [VW-1:0] src;
        logic [2*VW-1:0] prod;
        src = '0;
        prod = '0;

        case (config_r[CFG_RETX_LSB +: 2])
            RETX_SP: src = sp_nxt;
            RETX_CUR: src = meas_current_i;
            RETX_VOLT: src = meas_voltage_i;
            default: src = meas_power_i;
        endcase

        prod = src * {config_r[CFG_RSCALE_LSB +: 8], 8'h00};
        rt_nxt = prod[2*VW-1:VW];
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ctrl_o <= '0;
            alarm_o <= '0;
            alarm_relay_o <= 1'b0;
            setpoint_o <= '0;
            retransmit_o <= '0;
        end else begin
            ctrl_o <= ctrl_nxt;
            alarm_o <= alarm_nxt;
            alarm_relay_o <= relay_nxt;
            setpoint_o <= sp_nxt;
            retransmit_o <= rt_nxt;
        end
    end

    // Second analog input routed by its configured use
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ext_feedback_o <= '0;
            current_limit_sp_o <= '0;
            current_limit_sp_valid_o <= 1'b0;
        end else begin
            ext_feedback_o <= (config_r[CFG_AIN2_LSB +: 2] == AIN2_EXT_FB)
                              ? ain2_pct : '0;
            current_limit_sp_o <= (config_r[CFG_AIN2_LSB +: 2] == AIN2_CUR_LIM)
                                  ? ain2_pct : '0;
            current_limit_sp_valid_o <= (config_r[CFG_AIN2_LSB +: 2] == AIN2_CUR_LIM);
        end
    end

    // APB slave, zero wait states
    logic wr_en;
    logic hit;

    assign wr_en = psel_i && penable_i && pwrite_i;
    assign pready_o = 1'b1;
    assign hit = (paddr_i == OFS_DIN_FUNC) || (paddr_i == OFS_CONFIG)
                 || (paddr_i == OFS_AIN_RANGE1) || (paddr_i == OFS_AIN_RANGE2)
                 || (paddr_i == OFS_STATUS) || (paddr_i == OFS_SETPOINT)
                 || (paddr_i == OFS_AIN2_PCT) || (paddr_i == OFS_RETX);
    assign pslverr_o = psel_i && penable_i && !hit;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            din_func_r <= DIN_FUNC_RESET;
            config_r <= CFG_RESET;
            range1_r <= RANGE1_RESET;
            range2_r <= RANGE2_RESET;
        end else if (wr_en) begin
            if (paddr_i == OFS_DIN_FUNC) begin
                din_func_r <= {24'h00_0000, pwdata_i[7:0]};
            end else if (paddr_i == OFS_CONFIG) begin
                config_r <= pwdata_i;
            end else if (paddr_i == OFS_AIN_RANGE1) begin
                range1_r <= pwdata_i;
            end else if (paddr_i == OFS_AIN_RANGE2) begin
                range2_r <= pwdata_i;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            prdata_o <= '0;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            if (paddr_i == OFS_DIN_FUNC) begin
                prdata_o <= din_func_r;
            end else if (paddr_i == OFS_CONFIG) begin
                prdata_o <= config_r;
            end else if (paddr_i == OFS_AIN_RANGE1) begin
                prdata_o <= range1_r;
            end else if (paddr_i == OFS_AIN_RANGE2) begin
                prdata_o <= range2_r;
            end else if (paddr_i == OFS_STATUS) begin
                prdata_o <= {17'h0_0000, din_clean, alarm_relay_o, alarm_o, ctrl_o.power_on,
                             ctrl_o.local_sp, ctrl_o.remote_ain2, ctrl_o.logging_on,
                             ctrl_o.bakeout_on, ctrl_o.alarm_reset, ctrl_o.force_vfb};
            end else if (paddr_i == OFS_SETPOINT) begin
                prdata_o <= {16'h0000, setpoint_o};
            end else if (paddr_i == OFS_AIN2_PCT) begin
                prdata_o <= {16'h0000, ain2_pct};
            end else if (paddr_i == OFS_RETX) begin
                prdata_o <= {16'h0000, retransmit_o};
            end else begin
                prdata_o <= '0;
            end
        end
    end
endmodule : iofsar_top

// >>> testbench/iofsar_plc_model.sv
// Far-side controller model driving the two digital inputs
`timescale 1ns/10ps
module iofsar_plc_model (
    input wire logic clk_sys_i,
    input wire logic [1:0] level_i,
    output logic [1:0] din_o = 2'b00
);
    // Clean levels only; follow use is exercised with the firing type left at phase angle
    always_ff @(posedge clk_sys_i) begin
        din_o <= level_i;
    end
endmodule : iofsar_plc_model

// >>> testbench/iofsar_top_chk.sv
// Port checks on bus errors and alarm relay behaviour of iofsar_top
`timescale 1ns/10ps
module iofsar_top_chk (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [iofsar_pkg::DATA_W-1:0] pwdata_i,
    input wire logic pslverr_o,
    input wire logic aux_power_i,
    input wire logic heater_break_i,
    input wire logic thyristor_short_i,
    input wire logic limit_override_i,
    input wire logic watchdog_error_i,
    input wire logic heatsink_hot_i,
    input wire iofsar_pkg::iofsar_ctrl_t ctrl_o,
    input wire iofsar_pkg::iofsar_alarm_t alarm_o,
    input wire logic alarm_relay_o
);
    import iofsar_pkg::*;
    logic [31:0] cfg_r;
    logic cfg_wr;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);
    // Shadow of the config word; a write edge is excluded to avoid a race
    assign cfg_wr = psel_i && penable_i && pwrite_i && paddr_i == OFS_CONFIG;
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            cfg_r <= CFG_RESET;
        end else if (cfg_wr) begin
            cfg_r <= pwdata_i;
        end
    end
    property p_unmapped;
        psel_i && penable_i && paddr_i > OFS_RETX |-> pslverr_o;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("no error on unmapped access");
    property p_hot;
        heatsink_hot_i |=> !alarm_relay_o && alarm_o.heatsink_over_temp;
    endproperty
    a_hot: assert property (p_hot) else $error("relay held with hot sink");
    property p_no_aux;
        !aux_power_i |=> !alarm_relay_o;
    endproperty
    a_no_aux: assert property (p_no_aux) else $error("relay on without aux");
    property p_clear;
        aux_power_i && !(heater_break_i || thyristor_short_i || limit_override_i
            || watchdog_error_i || heatsink_hot_i) |=> alarm_relay_o;
    endproperty
    a_clear: assert property (p_clear) else $error("relay off with no alarm");
    property p_sel_wd;
        watchdog_error_i && cfg_r[CFG_ALM_LSB+ALM_WE] && !cfg_wr
            |=> !alarm_relay_o || ctrl_o.alarm_reset;
    endproperty
    a_sel_wd: assert property (p_sel_wd) else $error("selected alarm ignored");
    property p_unsel;
        !cfg_r[CFG_ALM_LSB+ALM_HB] && !cfg_wr |=> !alarm_o.heater_break_alarm;
    endproperty
    a_unsel: assert property (p_unsel) else $error("unselected break seen");
    property p_limit;
        limit_override_i |=> alarm_o.current_limit_alarm;
    endproperty
    a_limit: assert property (p_limit) else $error("limit alarm missing");
    property p_reset_hb;
        ctrl_o.alarm_reset |-> !alarm_o.heater_break_alarm;
    endproperty
    a_reset_hb: assert property (p_reset_hb) else $error("break kept in reset");
endmodule : iofsar_top_chk

// >>> testbench/test_iofsar_top.sv
// Self-checking bench for iofsar_top driven by a controller model
`timescale 1ns/10ps
module test_iofsar_top;
    import iofsar_pkg::*;
    localparam int DB = 2;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic clk_sys_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, e, m, seed = 32'h0000_003A;
    logic pready_o, pslverr_o, alarm_relay_o, current_limit_sp_valid_o;
    logic [1:0] din_i, lvl = 2'b00;
    logic lr_button_i = 1'b0, aux_power_i = 1'b1, demand_on_i = 1'b1, heatsink_hot_i = 1'b0;
    logic heater_break_i = 1'b0, thyristor_short_i = 1'b0, limit_override_i = 1'b0;
    logic watchdog_error_i = 1'b0;
    logic [15:0] ain1_i = 16'h2000, ain2_i = 16'h3000, local_sp_i = 16'h0000;
    logic [15:0] meas_current_i = 16'h0000, meas_voltage_i = 16'h0000;
    logic [15:0] meas_power_i = 16'h0000, setpoint_o, ext_feedback_o;
    logic [15:0] current_limit_sp_o, retransmit_o, src [4];
    iofsar_ctrl_t ctrl_o;
    iofsar_alarm_t alarm_o;
    logic [31:0] exq [$], mkq [$];
    int mismatches = 0, samples_checked = 0, cyc = 0;
    iofsar_fn_t fn [6] = '{IOFSAR_FN_VFB, IOFSAR_FN_ALARM_RESET, IOFSAR_FN_BAKEOUT,
        IOFSAR_FN_LOGGING, IOFSAR_FN_LOCAL_REMOTE, IOFSAR_FN_FOLLOW};
    int bt [6] = '{0, 1, 2, 3, 5, 6};
    // Conditions {break, short, limit, watchdog, hot, aux}; status {relay, hb, sc, il}
    logic [5:0] cv [7] = '{6'h21, 6'h11, 6'h09, 6'h05, 6'h03, 6'h00, 6'h01};
    logic [3:0] ev [7] = '{4'h4, 4'h8, 4'h9, 4'h0, 4'h0, 4'h0, 4'h8};
    iofsar_top #(.DEBOUNCE_COUNT(DB)) i_dut (.clk_sys_i, .reset_i, .psel_i, .penable_i,
        .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .din_i,
        .lr_button_i, .aux_power_i, .ain1_i, .ain2_i, .local_sp_i, .meas_current_i,
        .meas_voltage_i, .meas_power_i, .demand_on_i, .heater_break_i, .thyristor_short_i,
        .limit_override_i, .watchdog_error_i, .heatsink_hot_i, .ctrl_o, .alarm_o,
        .alarm_relay_o, .setpoint_o, .ext_feedback_o, .current_limit_sp_o,
        .current_limit_sp_valid_o, .retransmit_o);
    iofsar_plc_model i_plc (.clk_sys_i(clk_sys_i), .level_i(lvl), .din_o(din_i));
    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction : rnd
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : tick
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    // Reads note the expected word and mask; the monitor compares at the access edge
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [31:0] k);
        if (!w) begin
            exq.push_back(d);
            mkq.push_back(k);
        end
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do @(posedge clk_sys_i); while (pready_o !== 1'b1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        tick(2);
    endtask : bus
    // Debounce plus sync needs about count plus four cycles
    task automatic set(input logic [1:0] v);
        lvl <= v;
        tick(4 * DB + 8);
    endtask : set
    always @(posedge clk_sys_i) begin
        if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1 && exq.size() > 0) begin
            e = exq.pop_front();
            m = mkq.pop_front();
            samples_checked++;
            if ((prdata_o & m) !== (e & m)) begin
                mismatches++;
                $display("[FAIL] %0t got %h exp %h", $time, prdata_o & m, e & m);
            end
        end
    end
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    initial begin
        repeat (20) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        tick(1);
        bus(0, OFS_DIN_FUNC, DIN_FUNC_RESET, ALL);
        bus(0, OFS_CONFIG, CFG_RESET, ALL);
        bus(0, OFS_AIN_RANGE1, RANGE1_RESET, ALL);
        bus(0, OFS_AIN_RANGE2, RANGE2_RESET, ALL);
        bus(1, 12'h020, ALL, 32'h0000_0000);
        bus(0, 12'h020, 32'h0000_0000, ALL);
        bus(1, OFS_DIN_FUNC, 32'h0000_0001, 32'h0000_0000);
        bus(0, OFS_STATUS, 32'h0000_0000, 32'h0000_0040);
        set(2'b01);
        bus(0, OFS_STATUS, 32'h0000_2040, 32'h0000_6040);
        bus(1, OFS_DIN_FUNC, 32'h0000_0011, 32'h0000_0000);
        bus(0, OFS_STATUS, 32'h0000_0000, 32'h0000_0040);
        set(2'b10);
        lvl <= 2'b00;
        tick(1);
        lvl <= 2'b10;
        tick(12);
        bus(0, OFS_STATUS, 32'h0000_4040, 32'h0000_6040);
        demand_on_i <= 1'b0;
        set(2'b00);
        for (int i = 0; i < 6; i++) begin
            bus(1, OFS_DIN_FUNC, {28'h000_0000, fn[i]}, 32'h0000_0000);
            set(2'b01);
            bus(0, OFS_STATUS, 32'h1 << bt[i], 32'h1 << bt[i]);
            set(2'b00);
            bus(0, OFS_STATUS, 32'h0000_0000, 32'h1 << bt[i]);
        end
        bus(1, OFS_AIN_RANGE1, 32'h8000_0000, 32'h0000_0000);
        bus(1, OFS_AIN_RANGE2, 32'h5000_1000, 32'h0000_0000);
        local_sp_i <= rnd();
        bus(1, OFS_DIN_FUNC, 32'h0000_0053, 32'h0000_0000);
        set(2'b01);
        lr_button_i <= 1'b1;
        tick(2);
        lr_button_i <= 1'b0;
        tick(2);
        bus(0, OFS_STATUS, 32'h0000_0020, 32'h0000_0020);
        bus(0, OFS_SETPOINT, {16'h0000, local_sp_i}, ALL);
        set(2'b11);
        bus(0, OFS_SETPOINT, {16'h0000, local_sp_i}, ALL);
        set(2'b10);
        bus(0, OFS_STATUS, 32'h0000_0010, 32'h0000_0030);
        bus(0, OFS_SETPOINT, 32'h0000_8000, ALL);
        set(2'b00);
        bus(0, OFS_SETPOINT, 32'h0000_4000, ALL);
        bus(0, OFS_AIN2_PCT, 32'h0000_8000, ALL);
        bus(1, OFS_DIN_FUNC, 32'h0000_0008, 32'h0000_0000);
        bus(1, OFS_CONFIG, 32'h0009_0000, 32'h0000_0000);
        for (int i = 0; i < 7; i++) begin
            {heater_break_i, thyristor_short_i, limit_override_i, watchdog_error_i,
                heatsink_hot_i, aux_power_i} <= cv[i];
            tick(3);
            bus(0, OFS_STATUS, 32'(ev[i]) << 9, 32'h0000_1E20);
        end
        heater_break_i <= 1'b1;
        set(2'b01);
        bus(0, OFS_STATUS, 32'h0000_1000, 32'h0000_1800);
        heater_break_i <= 1'b0;
        bus(1, OFS_DIN_FUNC, 32'h0000_0003, 32'h0000_0000);
        {meas_current_i, meas_voltage_i, meas_power_i} <= {rnd(), rnd(), rnd()};
        tick(1);
        src = '{local_sp_i, meas_current_i, meas_voltage_i, meas_power_i};
        // Scale 0x80 halves the chosen source
        for (int s = 0; s < 4; s++) begin
            bus(1, OFS_CONFIG, 32'h8000_0000 | 32'(s << 20), 32'h0000_0000);
            bus(0, OFS_RETX, {17'h0_0000, src[s][15:1]}, ALL);
        end
        give_verdict();
    end
endmodule : test_iofsar_top
bind iofsar_top iofsar_top_chk i_chk (.clk_sys_i, .reset_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .pslverr_o, .aux_power_i, .heater_break_i, .thyristor_short_i,
    .limit_override_i, .watchdog_error_i, .heatsink_hot_i, .ctrl_o, .alarm_o, .alarm_relay_o);
